// >>> testbench/mcad_host.sv
// Host processor model on the banked I/O window
`timescale 1ns/1ns
module mcad_host (
   // Clock
   input wire logic i_clk,
   // Device answers
   input wire logic [15:0] i_io_rdata,
   input wire logic i_io_sel,
   input wire logic i_io_ready,
   // Host bus
   output logic [15:0] o_io_addr,
   output logic o_io_rd_n,
   output logic o_io_wr_n,
   output logic [15:0] o_io_wdata
);
   logic [15:0] rd_word;
   logic sel_seen;
   // Bus idle with both strobes high
   initial {o_io_rd_n, o_io_wr_n, o_io_addr, o_io_wdata} = {2'b11, 32'h0};
   // Request held until ready is sampled high; the first two edges precede any wait
   task automatic access(input logic [15:0] addr, input logic wr, input logic [15:0] data);
      int n;
      n = 0;
      o_io_addr <= addr;
      o_io_wdata <= wr ? data : ~data;
      o_io_rd_n <= wr;
      o_io_wr_n <= !wr;
      repeat (2) @(posedge i_clk);
      do begin
         @(posedge i_clk);
         n++;
      end while (i_io_ready !== 1'b1 && n < 40);
      rd_word = i_io_rdata;
      sel_seen = i_io_sel;
      // Released address and data show the inverse of addr and data; after a read the data lines keep the ~data they held
      o_io_rd_n <= 1'b1;
      o_io_wr_n <= 1'b1;
      o_io_addr <= ~addr;
      o_io_wdata <= ~data;
      @(posedge i_clk);
   endtask
   // The window is banked, so each register group needs a select first
   task automatic select_bank(input logic [15:0] base, input logic [1:0] bank);
      access(base + 16'h000e, 1'b1, {14'h0000, bank});
   endtask
endmodule

// >>> testbench/mcad_sva.sv
// Port assertions of the configuration register bank
`timescale 1ns/1ns
module mcad_sva (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Inputs
   input wire logic i_local_bus_mode,
   input wire logic i_width_strap_pin_n,
   input wire logic [15:0] i_io_addr,
   input wire logic [19:14] i_mem_addr,
   input wire logic i_memory_read_strobe_n,
   input wire logic i_link_pass,
   // Outputs
   input wire logic o_io_sel,
   input wire logic o_io_ready,
   input wire logic o_no_wait,
   input wire logic o_boot_sel,
   input wire logic o_bus_width_wide,
   input wire logic o_link_pulse_en,
   input wire logic o_link_ok,
   input wire logic o_tx_cable_en,
   input wire logic o_link_led,
   input wire logic [3:0] o_irq_oe_n
);
   logic [2:0] live_reg;
   // Outputs lag reset release by the synchroniser, so checks start later
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         live_reg <= 3'h0;
      end else if (live_reg != 3'h6) begin
         live_reg <= live_reg + 3'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst || live_reg != 3'h6);
   // Ten wait cycles, then ready again
   sequence wait_span;
      !o_io_ready [*8] ##1 !o_io_ready ##1 !o_io_ready ##1 o_io_ready;
   endsequence
   chk_wait_ten_cycles: assert property ($fell(o_io_ready) && !o_no_wait |-> wait_span)
      else $error("wait span wrong");
   chk_window_bits: assert property (
      i_io_addr[4] || i_io_addr[12:10] != 3'h0 |=> !o_io_sel) else $error("hit off window");
   chk_card_released: assert property (
      !i_local_bus_mode [*2] |=> o_irq_oe_n == 4'hf && !o_io_sel) else $error("card drives");
   chk_irq_one_pin: assert property ($countones(~o_irq_oe_n) <= 1)
      else $error("several irq pins");
   chk_width_strap: assert property (!i_width_strap_pin_n |=> o_bus_width_wide)
      else $error("width not forced");
   chk_link_test_off: assert property (
      !o_link_pulse_en |-> o_link_ok && o_link_led && o_tx_cable_en) else $error("link off");
   chk_link_fail_mute: assert property (
      o_link_pulse_en && !$past(i_link_pass) |-> !o_link_ok && !o_tx_cable_en)
      else $error("failed link not muted");
   chk_boot_read_only: assert property (
      i_memory_read_strobe_n || !i_mem_addr[19] |=> !o_boot_sel) else $error("boot hit");
endmodule
bind mcad_top mcad_sva mcad_sva_inst (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_local_bus_mode(i_local_bus_mode), .i_width_strap_pin_n(i_width_strap_pin_n),
   .i_io_addr(i_io_addr), .i_mem_addr(i_mem_addr),
   .i_memory_read_strobe_n(i_memory_read_strobe_n), .i_link_pass(i_link_pass),
   .o_io_sel(o_io_sel), .o_io_ready(o_io_ready), .o_no_wait(o_no_wait),
   .o_boot_sel(o_boot_sel), .o_bus_width_wide(o_bus_width_wide),
   .o_link_pulse_en(o_link_pulse_en), .o_link_ok(o_link_ok), .o_tx_cable_en(o_tx_cable_en),
   .o_link_led(o_link_led), .o_irq_oe_n(o_irq_oe_n));

// >>> testbench/tb_mac_config_address_decode.sv
// Bench for the configuration register bank with a host model
`timescale 1ns/1ns
module tb_mac_config_address_decode;
   logic clk = 1'b0, nrst = 1'b0, lm = 1'b1, strap_n = 1'b1, srst = 1'b0, mrd_n = 1'b1;
   logic mmu = 1'b0, eld = 1'b0, lpass = 1'b1;
   logic [7:0] free = 8'h18;
   logic [5:0] ea = 6'h20;
   logic [15:0] ed = 16'h0000, base = 16'h0300, ad, wd, rdat;
   logic rd_n, wr_n, sel, rdy, deny, wen, fstep, sq, aui, wide, pen, lok, txe, led;
   logic [3:0] oe_n, irqo;
   logic [5:0] maddr = 6'h33;
   logic boot, dpw = 1'b0, eb = 1'b0;
   logic [15:0] ewd;
   logic [47:0] sta;
   int bad_count = 0, total_checks = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   mcad_top mcad_top_inst (.i_clk(clk), .i_nrst(nrst), .i_local_bus_mode(lm),
      .i_width_strap_pin_n(strap_n), .i_soft_reset(srst), .i_io_addr(ad), .i_io_rd_n(rd_n),
      .i_io_wr_n(wr_n), .i_io_wdata(wd), .i_data_port_wait(dpw), .o_io_rdata(rdat),
      .o_io_sel(sel), .o_io_ready(rdy), .i_mem_addr(maddr), .i_memory_read_strobe_n(mrd_n),
      .o_boot_sel(boot), .i_free_pages(free), .i_size_pages(8'h18), .i_mmu_reset(mmu),
      .o_rx_deny(deny), .i_ee_busy(eb), .i_ee_load(eld), .i_ee_addr(ea), .i_ee_data(ed),
      .o_ee_wdata(ewd), .o_ee_wen(wen), .i_link_pass(lpass), .o_full_step(fstep),
      .o_squelch_low(sq), .o_aui_sel(aui), .o_bus_width_wide(wide), .o_link_pulse_en(pen),
      .o_link_ok(lok), .o_tx_cable_en(txe), .o_link_led(led), .o_no_wait(),
      .o_station_address(sta), .i_irq(1'b1), .o_irq_out(irqo), .o_irq_oe_n(oe_n));
   mcad_host mcad_host_inst (.i_clk(clk), .i_io_rdata(rdat), .i_io_sel(sel), .i_io_ready(rdy),
      .o_io_addr(ad), .o_io_rd_n(rd_n), .o_io_wr_n(wr_n), .o_io_wdata(wd));
   // Case equality, so an unknown never passes
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic [3:0] off, input logic w, input logic [15:0] d);
      mcad_host_inst.access(base + {12'h000, off}, w, d);
   endtask
   task automatic rd(input logic [3:0] off, input logic [15:0] exp);
      acc(off, 1'b0, exp);
      check(mcad_host_inst.rd_word, exp);
      check(mcad_host_inst.sel_seen, 1'b1);
   endtask
   // One serial-memory word delivered to the bank
   task automatic ee(input logic [5:0] a, input logic [15:0] d);
      ea <= a;
      ed <= d;
      eld <= 1'b1;
      @(posedge clk);
      eld <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic end_sim;
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      mcad_host_inst.select_bank(base, 2'h0);
      rd(4'ha, 16'h3300);
      rd(4'h8, 16'h1818);
      acc(4'ha, 1'b1, 16'hffff);
      mmu <= 1'b1;
      @(posedge clk);
      mmu <= 1'b0;
      rd(4'ha, 16'h33ff);
      check(deny, 1'b1);
      acc(4'ha, 1'b1, 16'h0010);
      free <= 8'h11;
      repeat (3) @(posedge clk);
      check(deny, 1'b0);
      free <= 8'h10;
      repeat (3) @(posedge clk);
      check(deny, 1'b1);
      acc(4'ha, 1'b1, 16'h0000);
      free <= 8'h00;
      repeat (3) @(posedge clk);
      check(deny, 1'b0);
      mcad_host_inst.select_bank(base, 2'h1);
      rd(4'h0, 16'h3000);
      rd(4'h2, 16'h1867);
      rd(4'hc, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         acc(4'h0, 1'b1, 16'h3002 | (16'(i) << 9));
         check(oe_n, 4'(~(4'h1 << i)));
      end
      check(irqo, 4'hf);
      check({fstep, sq, aui}, 3'h2);
      acc(4'h0, 1'b1, 16'h3005);
      check({fstep, sq, aui}, 3'h5);
      lpass <= 1'b0;
      acc(4'h0, 1'b1, 16'h7010);
      check({pen, lok, txe, led}, 4'h7);
      acc(4'h0, 1'b1, 16'h3010);
      check({pen, lok, txe}, 3'h4);
      lpass <= 1'b1;
      strap_n <= 1'b0;
      @(posedge clk);
      rd(4'h0, 16'hb010);
      check(wide, 1'b1);
      strap_n <= 1'b1;
      mcad_host_inst.select_bank(base, 2'h0);
      acc(4'ha, 1'b1, 16'h0020);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(4'ha, 16'h3300);
      mcad_host_inst.select_bank(base, 2'h1);
      rd(4'h0, 16'hb010);
      // Writes while the serial memory owns the bank are dropped
      eb <= 1'b1;
      acc(4'h0, 1'b1, 16'h0000);
      eb <= 1'b0;
      rd(4'h0, 16'hb010);
      // Data port not ready stretches an access even with no-wait set
      dpw <= 1'b1;
      fork
         rd(4'h2, 16'h1867);
         begin
            repeat (5) @(posedge clk);
            check(rdy, 1'b0);
            dpw <= 1'b0;
         end
      join
      ee(6'h20, 16'ha5c3);
      check(sta[7:0], 8'hc3);
      check(wen, 1'b0);
      rd(4'h4, 16'ha5c3);
      ee(6'h01, 16'h1a67);
      check(wen, 1'b1);
      check(ewd, 16'h1a67);
      base = 16'h0340;
      rd(4'h2, 16'h1a67);
      mcad_host_inst.access(16'h0352, 1'b0, 16'h0000);
      check(mcad_host_inst.sel_seen, 1'b0);
      lm <= 1'b0;
      ee(6'h00, 16'h3001);
      check({oe_n, aui}, 5'h1e);
      lm <= 1'b1;
      ee(6'h00, 16'h3001);
      check(aui, 1'b1);
      mrd_n <= 1'b0;
      repeat (3) @(posedge clk);
      check(boot, 1'b1);
      maddr <= 6'h30;
      repeat (2) @(posedge clk);
      check(boot, 1'b0);
      mrd_n <= 1'b1;
      // 64k window compares only the top three base bits
      base = 16'h0300;
      acc(4'h2, 1'b1, 16'h18e7);
      mrd_n <= 1'b0;
      repeat (3) @(posedge clk);
      check(boot, 1'b1);
      mrd_n <= 1'b1;
      repeat (2) @(posedge clk);
      check(boot, 1'b0);
      end_sim();
   end
endmodule

// >>> verilog/mcad_defines.svh
// Offsets, serial memory addresses, reset values and timing counts of the register bank
`ifndef MCAD_DEFINES_SVH
`define MCAD_DEFINES_SVH
// Word offsets inside the 16-location window
`define MCAD_OFF_CFG 4'h0
`define MCAD_OFF_BASE 4'h2
`define MCAD_OFF_STA0 4'h4
`define MCAD_OFF_STA1 4'h6
`define MCAD_OFF_STA2 4'h8
`define MCAD_OFF_MINFO 4'h8
`define MCAD_OFF_MCFG 4'ha
`define MCAD_OFF_BANK 4'he
`define MCAD_BANK0 2'h0
`define MCAD_BANK1 2'h1
// Serial memory word addresses
`define MCAD_EE_CFG 6'h00
`define MCAD_EE_BASE 6'h01
`define MCAD_EE_STA 6'h20
// Reset values
`define MCAD_CFG_RST 16'h3000
`define MCAD_BASE_RST 16'h1867
`define MCAD_MCFG_HIGH 8'h33
`define MCAD_RES_RST 8'h00
// Wait timing: 2 cycles of 20 MHz, counted at 100 MHz
`define MCAD_WAIT_NS 100
`define MCAD_CLK_NS 10
`define MCAD_WAIT_CYC ((`MCAD_WAIT_NS + `MCAD_CLK_NS - 1) / `MCAD_CLK_NS)
`endif

// >>> verilog/mcad_pkg.sv
// Types of the configuration register bank
package mcad_pkg;
   typedef struct packed {
      logic wide;
      logic link_dis;
      logic [2:0] rsv_hi;
      logic [1:0] irq_sel;
      logic rsv_a;
      logic rsv_b;
      logic [1:0] rsv_c;
      logic no_wait;
      logic rsv_d;
      logic full_step;
      logic squelch_low;
      logic aui_sel;
   } mcad_cfg_type;
   typedef enum logic [1:0] {
      MCAD_IDLE = 2'b00,
      MCAD_WAIT = 2'b01,
      MCAD_HOLD = 2'b10
   } mcad_bus_type;
endpackage

// >>> verilog/mcad_top.sv
// Configuration register bank with I/O and boot window decode
`timescale 1ns/1ns
`include "mcad_defines.svh"

// Overview of operation
// - Zero reserve means fully dynamic sharing.
// - Deny receive when free not above reserve.
// - Reserve clears on reset, survives memory reset.
// - Counts are 256 times multiplier bytes.
// - Bits 11-9 read-only multiplier code.
// - Ready low ten cycles unless no-wait.
// - Full step only with attachment port.
// - Squelch bit selects low threshold.
// - Port bit selects attachment interface.
// - Width bit forced high by strap low.
// - Link test disable forces link good.
// - Failed link blocks cable data, link good and LED.
// - Interrupt select drives one of four.
// - I/O window matched on base bits.
// - ROM size field picks compared bits.
// - ROM hit only on memory reads.
// - Base defaults 1867h, card mode too.
// - Configuration word loads in local mode.
// - Base loads from memory in local mode.
// - Station address loads from 20h, never stored.
// - Bit 0 first on the cable.
// - Reload rereads config, base, station address.
// - Soft reset keeps config, base, station.
module mcad_top (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Straps and soft reset
   input wire logic i_local_bus_mode,
   input wire logic i_width_strap_pin_n,
   input wire logic i_soft_reset,
   // Host I/O bus
   input wire logic [15:0] i_io_addr,
   input wire logic i_io_rd_n,
   input wire logic i_io_wr_n,
   input wire logic [15:0] i_io_wdata,
   input wire logic i_data_port_wait,
   output logic [15:0] o_io_rdata,
   output logic o_io_sel,
   output logic o_io_ready,
   // Boot memory decode
   input wire logic [19:14] i_mem_addr,
   input wire logic i_memory_read_strobe_n,
   output logic o_boot_sel,
   // Memory manager
   input wire logic [7:0] i_free_pages,
   input wire logic [7:0] i_size_pages,
   input wire logic i_mmu_reset,
   output logic o_rx_deny,
   // Serial configuration memory
   input wire logic i_ee_busy,
   input wire logic i_ee_load,
   input wire logic [5:0] i_ee_addr,
   input wire logic [15:0] i_ee_data,
   output logic [15:0] o_ee_wdata,
   output logic o_ee_wen,
   // Media controls
   input wire logic i_link_pass,
   output logic o_full_step,
   output logic o_squelch_low,
   output logic o_aui_sel,
   output logic o_bus_width_wide,
   output logic o_link_pulse_en,
   output logic o_link_ok,
   output logic o_tx_cable_en,
   output logic o_link_led,
   output logic o_no_wait,
   output logic [47:0] o_station_address,
   // Interrupt pins
   input wire logic i_irq,
   output logic [3:0] o_irq_out,
   output logic [3:0] o_irq_oe_n
);

   logic rst_s1_reg;
   logic rst_n;
   mcad_pkg::mcad_cfg_type cfg_reg;
   logic [15:0] base_reg;
   logic [47:0] sta_reg;
   logic [7:0] res_reg;
   logic [1:0] bank_reg;
   mcad_pkg::mcad_bus_type bus_reg;
   logic [3:0] wcnt_reg;
   logic rd_q_reg;
   logic wr_q_reg;
   logic io_hit;
   logic rom_hit;
   logic acc_start;
   logic wr_en;
   logic [3:0] off;
   logic [15:0] rd_mux;
   logic wide_next;

   // Reset release through two flip-flops
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // I/O window: A15-A13 and A9-A5 compared, A12-A10 and A4 zero
   assign io_hit = i_local_bus_mode
      && (i_io_addr[15:13] == base_reg[15:13])
      && (i_io_addr[9:5] == base_reg[12:8])
      && (i_io_addr[12:10] == 3'h0)
      && !i_io_addr[4];
   assign off = i_io_addr[3:0];
   assign acc_start = io_hit && ((!i_io_rd_n && rd_q_reg) || (!i_io_wr_n && wr_q_reg));
   // Writes ignored while the serial memory owns the bank
   assign wr_en = io_hit && !i_io_wr_n && wr_q_reg && !i_ee_busy;

   // Boot window: the size field chooses how many base bits count
   always_comb begin
      unique case (base_reg[7:6])
         2'b00: rom_hit = 1'b0;
         2'b01: rom_hit = i_mem_addr[18:14] == base_reg[5:1];
         2'b10: rom_hit = i_mem_addr[18:15] == base_reg[5:2];
         2'b11: rom_hit = i_mem_addr[18:16] == base_reg[5:3];
      endcase
   end

   // Strobe history for edge detection
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q_reg <= 1'b1;
         wr_q_reg <= 1'b1;
      end else begin
         rd_q_reg <= i_io_rd_n;
         wr_q_reg <= i_io_wr_n;
      end
   end

   // Bank select; soft reset returns to bank 0
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_reg <= `MCAD_BANK0;
      end else if (i_soft_reset) begin
         bank_reg <= `MCAD_BANK0;
      end else if (wr_en && off == `MCAD_OFF_BANK) begin
         bank_reg <= i_io_wdata[1:0];
      end
   end

   // Transmit reserve: cleared by resets, untouched by memory reset
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_reg <= `MCAD_RES_RST;
      end else if (i_soft_reset) begin
         res_reg <= `MCAD_RES_RST;
      end else if (wr_en && bank_reg == `MCAD_BANK0 && off == `MCAD_OFF_MCFG) begin
         res_reg <= i_io_wdata[7:0];
      end
   end

   // Receive refusal; units are pages of 256*M bytes on both sides
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rx_deny <= 1'b0;
      end else begin
         // Zero reserve never denies, giving full sharing
         o_rx_deny <= (res_reg != 8'h00) && (i_free_pages <= res_reg);
      end
   end

   // Width bit: strap low forces it high
   assign wide_next = (wr_en && bank_reg == `MCAD_BANK1 && off == `MCAD_OFF_CFG)
      ? i_io_wdata[15] : cfg_reg.wide;

   // Configuration word: soft reset keeps it; card mode skips the load
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= `MCAD_CFG_RST;
      end else begin
         if (i_ee_load && i_local_bus_mode && i_ee_addr == `MCAD_EE_CFG) begin
            cfg_reg <= i_ee_data;
         end else if (wr_en && bank_reg == `MCAD_BANK1 && off == `MCAD_OFF_CFG) begin
            cfg_reg <= i_io_wdata;
         end
         if (!i_width_strap_pin_n) begin
            cfg_reg.wide <= 1'b1;
         end else if (!(i_ee_load && i_local_bus_mode && i_ee_addr == `MCAD_EE_CFG)) begin
            cfg_reg.wide <= wide_next;
         end
      end
   end

   // Base register: default in card mode, load in local mode only
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_reg <= `MCAD_BASE_RST;
      end else if (!i_local_bus_mode) begin
         base_reg <= `MCAD_BASE_RST;
      end else if (i_ee_load && i_ee_addr == `MCAD_EE_BASE) begin
         base_reg <= i_ee_data;
      end else if (wr_en && bank_reg == `MCAD_BANK1 && off == `MCAD_OFF_BASE) begin
         base_reg <= i_io_wdata;
      end
   end

   // Station address: byte 0 in bits 7:0, bit 0 goes first on the cable
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sta
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               sta_reg[gi*16 +: 16] <= 16'h0000;
            end else if (i_ee_load && i_ee_addr == `MCAD_EE_STA + 6'(gi)) begin
               sta_reg[gi*16 +: 16] <= i_ee_data;
            end else if (wr_en && bank_reg == `MCAD_BANK1
                  && off == `MCAD_OFF_STA0 + 4'(2 * gi)) begin
               sta_reg[gi*16 +: 16] <= i_io_wdata;
            end
         end
      end
   endgenerate

   // Store path: only config and base go out, station words never
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_ee_wdata <= 16'h0000;
         o_ee_wen <= 1'b0;
      end else begin
         o_ee_wen <= i_local_bus_mode
            && (i_ee_addr == `MCAD_EE_CFG || i_ee_addr == `MCAD_EE_BASE);
         o_ee_wdata <= (i_ee_addr == `MCAD_EE_BASE) ? base_reg : cfg_reg;
      end
   end

   // Read data selection by bank and offset
   always_comb begin
      rd_mux = 16'h0000;
      if (off == `MCAD_OFF_BANK) begin
         rd_mux = {14'h0000, bank_reg};
      end else if (bank_reg == `MCAD_BANK0) begin
         if (off == `MCAD_OFF_MINFO) begin
            rd_mux = {i_size_pages, i_free_pages};
         end else if (off == `MCAD_OFF_MCFG) begin
            rd_mux = {`MCAD_MCFG_HIGH, res_reg};
         end
      end else if (bank_reg == `MCAD_BANK1) begin
         unique case (off)
            `MCAD_OFF_CFG: rd_mux = cfg_reg;
            `MCAD_OFF_BASE: rd_mux = base_reg;
            `MCAD_OFF_STA0: rd_mux = sta_reg[15:0];
            `MCAD_OFF_STA1: rd_mux = sta_reg[31:16];
            `MCAD_OFF_STA2: rd_mux = sta_reg[47:32];
            default: rd_mux = 16'h0000;
         endcase
      end
   end

   // Read data latched while the read strobe is low
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_io_rdata <= 16'h0000;
         o_io_sel <= 1'b0;
      end else begin
         o_io_sel <= io_hit && (!i_io_rd_n || !i_io_wr_n);
         if (io_hit && !i_io_rd_n) begin
            o_io_rdata <= rd_mux;
         end
      end
   end

   // Wait-state sequencer: ready low for the count after a strobe edge
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_reg <= mcad_pkg::MCAD_IDLE;
         wcnt_reg <= 4'h0;
         o_io_ready <= 1'b1;
      end else begin
         unique case (bus_reg)
            mcad_pkg::MCAD_IDLE: begin
               if (acc_start && !cfg_reg.no_wait) begin
                  bus_reg <= mcad_pkg::MCAD_WAIT;
                  wcnt_reg <= 4'(`MCAD_WAIT_CYC);
                  o_io_ready <= 1'b0;
               end else if (acc_start && i_data_port_wait) begin
                  bus_reg <= mcad_pkg::MCAD_HOLD;
                  o_io_ready <= 1'b0;
               end
            end
            mcad_pkg::MCAD_WAIT: begin
               if (wcnt_reg == 4'h1) begin
                  bus_reg <= mcad_pkg::MCAD_IDLE;
                  o_io_ready <= 1'b1;
               end
               wcnt_reg <= wcnt_reg - 4'h1;
            end
            mcad_pkg::MCAD_HOLD: begin
               // Data port not ready stretches even with no-wait set
               if (!i_data_port_wait) begin
                  bus_reg <= mcad_pkg::MCAD_IDLE;
                  o_io_ready <= 1'b1;
               end
            end
            default: begin
               bus_reg <= mcad_pkg::MCAD_IDLE;
               o_io_ready <= 1'b1;
            end
         endcase
      end
   end

   // Boot memory select, reads only
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_boot_sel <= 1'b0;
      end else begin
         o_boot_sel <= i_local_bus_mode && !i_memory_read_strobe_n
            && i_mem_addr[19] && rom_hit;
      end
   end

   // Media control outputs
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_full_step <= 1'b0;
         o_squelch_low <= 1'b0;
         o_aui_sel <= 1'b0;
         o_bus_width_wide <= 1'b0;
         o_no_wait <= 1'b0;
         o_station_address <= 48'h0;
      end else begin
         o_full_step <= cfg_reg.full_step && cfg_reg.aui_sel;
         o_squelch_low <= cfg_reg.squelch_low;
         o_aui_sel <= cfg_reg.aui_sel;
         o_bus_width_wide <= cfg_reg.wide || !i_width_strap_pin_n;
         o_no_wait <= cfg_reg.no_wait;
         o_station_address <= sta_reg;
      end
   end

   // Link test: disable forces good; failure gates cable data, link good and LED
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_link_pulse_en <= 1'b0;
         o_link_ok <= 1'b0;
         o_tx_cable_en <= 1'b0;
         o_link_led <= 1'b0;
      end else begin
         o_link_pulse_en <= !cfg_reg.link_dis;
         o_link_ok <= cfg_reg.link_dis || i_link_pass;
         o_tx_cable_en <= cfg_reg.link_dis || i_link_pass;
         o_link_led <= cfg_reg.link_dis || i_link_pass;
      end
   end

   // Interrupt pins: one driven in local mode, all released otherwise
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_irq
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               o_irq_out[gi] <= 1'b0;
               o_irq_oe_n[gi] <= 1'b1;
            end else begin
               o_irq_out[gi] <= i_irq;
               o_irq_oe_n[gi] <= !(i_local_bus_mode
                  && cfg_reg.irq_sel == 2'(gi));
            end
         end
      end
   endgenerate

endmodule
